// File: common/dds_consts.vh
// Notes on behaviour
// - accumulator steps by exactly one frequency word
// - exactly one phase offset added to accumulator
// - frequency choice from pin or control bit
// - phase choice from pin or control bit
// - reset input clears accumulator, output zero
// - reset input leaves software registers untouched
// - powerdown pin high powers down the DAC
// - powerdown pin and bit act alike
// - both logic bits set route comparator input
// - output frequency is word fraction of clock
// - logic pin driven only when output enabled
`ifndef DDS_CONSTS_VH
`define DDS_CONSTS_VH

// widths of the datapath
`define FREQ_W        28
`define PHASE_W       12
`define ADDR_W        8

// register byte offsets
`define OFS_CONTROL   8'h00
`define OFS_FREQ_A    8'h04
`define OFS_FREQ_B    8'h08
`define OFS_PHASE_A   8'h0C
`define OFS_PHASE_B   8'h10
`define OFS_STATUS    8'h14
`define OFS_ACCUM     8'h18

// control register fields
`define CTL_FREQ_SEL  0
`define CTL_PHASE_SEL 1
`define CTL_PIN_CTRL  2
`define CTL_DAC_PD    3
`define CTL_OUT_EN    4
`define CTL_OUT_SRC   5
`define CTL_W         6

// status register fields
`define STA_FREQ_SEL  0
`define STA_PHASE_SEL 1
`define STA_DAC_PD    2
`define STA_IN_RESET  3
`define STA_COMP      4
`define STA_MSB       5
`define STA_ROUTE     6
`define STA_W         7

// reset values of software registers
`define CONTROL_RST   6'h00
`define FREQ_RST      28'h0000000
`define PHASE_RST     12'h000

`endif

// File: rtl/dds_tuning_select_control.v
`timescale 1ns/1ps
`include "dds_consts.vh"

module dds_tuning_select_control (
    input  wire                 CLK_SYS,
    input  wire                 NRST,
    input  wire                 PSEL,
    input  wire                 PENABLE,
    input  wire                 PWRITE,
    input  wire [`ADDR_W-1:0]   PADDR,
    input  wire [31:0]          PWDATA,
    output reg  [31:0]          PRDATA,
    output reg                  PREADY,
    output reg                  PSLVERR,
    input  wire                 FREQ_SELECT_PIN,
    input  wire                 PHASE_SELECT_PIN,
    input  wire                 DDS_RESET_PIN,
    input  wire                 DAC_POWERDOWN_PIN,
    input  wire                 COMPARATOR_RESULT,
    output reg  [`PHASE_W-1:0]  PHASE_OUT,
    output reg                  DAC_POWERDOWN,
    output reg                  COMPARATOR_INPUT_SEL,
    output reg                  LOGIC_OUTPUT_PIN,
    output reg                  LOGIC_OUTPUT_OE
);

    // software registers
    reg  [`CTL_W-1:0]   control_q;
    reg  [`FREQ_W-1:0]  freq_word_a_q;
    reg  [`FREQ_W-1:0]  freq_word_b_q;
    reg  [`PHASE_W-1:0] phase_offset_a_q;
    reg  [`PHASE_W-1:0] phase_offset_b_q;

    // pin synchronisers, first stage read only by second
    reg                 freq_select_bit_meta_q;
    reg                 freq_select_bit_sync_q;
    reg                 psel_meta_q;
    reg                 psel_sync_q;
    reg                 rst_meta_q;
    reg                 rst_sync_q;
    reg                 pd_meta_q;
    reg                 pd_sync_q;
    reg                 comp_meta_q;
    reg                 comp_sync_q;

    // datapath state
    reg  [`FREQ_W-1:0]  accum_q;
    reg  [`FREQ_W-1:0]  accum_d;
    reg  [`PHASE_W-1:0] phase_d;

    // bus side signals
    reg  [31:0]         rdata_d;
    reg                 slverr_d;
    wire                access;
    wire                wr_en;
    wire                addr_hit;

    // control fields
    wire                freq_select_bit;
    wire                phase_select_bit;
    wire                pin_ctrl;
    wire                dac_powerdown_bit;
    wire                logic_output_enable;
    wire                logic_output_source;

    // effective selections
    wire                freq_sel;
    wire                phase_sel;
    wire [`FREQ_W-1:0]  freq_word;
    wire [`PHASE_W-1:0] phase_offset;
    wire                accum_msb;
    reg                 logic_pin_d;

    // picks pin or bit as the active selection source
    // one mux serves frequency and phase alike
    function pick_src;
        input use_pin;
        input pin_val;
        input bit_val;
        begin
            pick_src = use_pin ? pin_val : bit_val;
        end
    endfunction

    // true when the address names a mapped register
    function is_mapped;
        input [`ADDR_W-1:0] a;
        begin
            case (a)
                `OFS_CONTROL,
                `OFS_FREQ_A,
                `OFS_FREQ_B,
                `OFS_PHASE_A,
                `OFS_PHASE_B,
                `OFS_STATUS,
                `OFS_ACCUM:   is_mapped = 1'b1;
                default:      is_mapped = 1'b0;
            endcase
        end
    endfunction

    // power-down asked by the pin or by the control bit
    function pd_request;
        input pin_req;
        input bit_req;
        begin
            pd_request = pin_req | bit_req;
        end
    endfunction

    // comparator takes the external input only when both bits set
    function ext_route;
        input out_en;
        input out_src;
        begin
            ext_route = out_en & out_src;
        end
    endfunction

    // control field split
    assign freq_select_bit     = control_q[`CTL_FREQ_SEL];
    assign phase_select_bit    = control_q[`CTL_PHASE_SEL];
    assign pin_ctrl            = control_q[`CTL_PIN_CTRL];
    assign dac_powerdown_bit   = control_q[`CTL_DAC_PD];
    assign logic_output_enable = control_q[`CTL_OUT_EN];
    assign logic_output_source = control_q[`CTL_OUT_SRC];

    // two-stage sync of every pin input
    // pins run off clock, so never read raw
    // sample on clock
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            freq_select_bit_meta_q <= 1'b0;
            freq_select_bit_sync_q <= 1'b0;
            psel_meta_q <= 1'b0;
            psel_sync_q <= 1'b0;
            rst_meta_q  <= 1'b0;
            rst_sync_q  <= 1'b0;
            pd_meta_q   <= 1'b0;
            pd_sync_q   <= 1'b0;
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end else begin
            freq_select_bit_meta_q <= FREQ_SELECT_PIN;
            freq_select_bit_sync_q <= freq_select_bit_meta_q;
            psel_meta_q <= PHASE_SELECT_PIN;
            psel_sync_q <= psel_meta_q;
            rst_meta_q  <= DDS_RESET_PIN;
            rst_sync_q  <= rst_meta_q;
            pd_meta_q   <= DAC_POWERDOWN_PIN;
            pd_sync_q   <= pd_meta_q;
            comp_meta_q <= COMPARATOR_RESULT;
            comp_sync_q <= comp_meta_q;
        end
    end

    // source of the selection: pins or bits, never both
    // single source
    assign freq_sel  = pick_src(pin_ctrl, freq_select_bit_sync_q, freq_select_bit);
    assign phase_sel = pick_src(pin_ctrl, psel_sync_q, phase_select_bit);

    assign freq_word    = freq_sel ? freq_word_b_q : freq_word_a_q;
    assign phase_offset = phase_sel ? phase_offset_b_q : phase_offset_a_q;
    assign accum_msb    = accum_q[`FREQ_W-1];

    // next accumulator and phase word
    // wraps modulo the word width, never saturates
    always @* begin
        accum_d = accum_q;
        phase_d = {`PHASE_W{1'b0}};
        if (rst_sync_q) begin
            accum_d = {`FREQ_W{1'b0}};
            phase_d = {`PHASE_W{1'b0}};
        end else begin
            accum_d = accum_q + freq_word;
            phase_d = accum_q[`FREQ_W-1 -: `PHASE_W] + phase_offset;
        end
    end

    // datapath registers; the reset pin reaches only these
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            accum_q   <= {`FREQ_W{1'b0}};
            PHASE_OUT <= {`PHASE_W{1'b0}};
        end else begin
            accum_q   <= accum_d;
            PHASE_OUT <= phase_d;
        end
    end

    // next logic pin level; low while off so no stale level
    // source select
    always @* begin
        logic_pin_d = 1'b0;
        if (logic_output_enable) begin
            logic_pin_d = logic_output_source ? comp_sync_q : accum_msb;
        end
    end

    // output routing, all registered
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            DAC_POWERDOWN        <= 1'b0;
            COMPARATOR_INPUT_SEL <= 1'b0;
            LOGIC_OUTPUT_PIN     <= 1'b0;
            LOGIC_OUTPUT_OE      <= 1'b0;
        end else begin
            DAC_POWERDOWN        <= pd_request(pd_sync_q, dac_powerdown_bit);
            COMPARATOR_INPUT_SEL <= ext_route(logic_output_enable,
                                              logic_output_source);
            LOGIC_OUTPUT_OE      <= logic_output_enable;
            LOGIC_OUTPUT_PIN     <= logic_pin_d;
        end
    end

    // apb decode: one wait state, write lands with pready
    // writes to read-only offsets drop quietly
    assign access   = PSEL & PENABLE;
    assign wr_en    = access & PWRITE & PREADY & ~PSLVERR;
    assign addr_hit = is_mapped(PADDR);

    // read data and error prepared in the wait state
    // unused upper bits always read as zero
    always @* begin
        rdata_d  = 32'h00000000;
        slverr_d = ~addr_hit;
        if (!PWRITE) begin
            case (PADDR)
                `OFS_CONTROL: rdata_d[`CTL_W-1:0]   = control_q;
                `OFS_FREQ_A:  rdata_d[`FREQ_W-1:0]  = freq_word_a_q;
                `OFS_FREQ_B:  rdata_d[`FREQ_W-1:0]  = freq_word_b_q;
                `OFS_PHASE_A: rdata_d[`PHASE_W-1:0] = phase_offset_a_q;
                `OFS_PHASE_B: rdata_d[`PHASE_W-1:0] = phase_offset_b_q;
                `OFS_STATUS: begin
                    rdata_d[`STA_FREQ_SEL]  = freq_sel;
                    rdata_d[`STA_PHASE_SEL] = phase_sel;
                    rdata_d[`STA_DAC_PD]    = pd_request(pd_sync_q,
                                              dac_powerdown_bit);
                    rdata_d[`STA_IN_RESET]  = rst_sync_q;
                    rdata_d[`STA_COMP]      = comp_sync_q;
                    rdata_d[`STA_MSB]       = accum_msb;
                    rdata_d[`STA_ROUTE]     = ext_route(logic_output_enable,
                                              logic_output_source);
                end
                `OFS_ACCUM:   rdata_d[`FREQ_W-1:0]  = accum_q;
                default:      rdata_d = 32'h00000000;
            endcase
        end
    end

    // handshake: pready rises one cycle into the access phase
    // fixed single wait keeps decode off the bus path
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else if (access && !PREADY) begin
            PREADY  <= 1'b1;
            PSLVERR <= slverr_d;
            PRDATA  <= rdata_d;
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end
    end

    // software registers, cleared only by the bus reset
    // untouched by dds reset
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            control_q        <= `CONTROL_RST;
            freq_word_a_q    <= `FREQ_RST;
            freq_word_b_q    <= `FREQ_RST;
            phase_offset_a_q <= `PHASE_RST;
            phase_offset_b_q <= `PHASE_RST;
        end else if (wr_en) begin
            case (PADDR)
                `OFS_CONTROL: control_q        <= PWDATA[`CTL_W-1:0];
                `OFS_FREQ_A:  freq_word_a_q    <= PWDATA[`FREQ_W-1:0];
                `OFS_FREQ_B:  freq_word_b_q    <= PWDATA[`FREQ_W-1:0];
                `OFS_PHASE_A: phase_offset_a_q <= PWDATA[`PHASE_W-1:0];
                `OFS_PHASE_B: phase_offset_b_q <= PWDATA[`PHASE_W-1:0];
                // status and accumulator are read only
                default:      control_q        <= control_q;
            endcase
        end
    end

endmodule // dds_tuning_select_control

// File: testbench/dds_sel_checker_asserts.sv
`timescale 1ns/1ps
module dds_sel_checker (
    input logic        CLK_SYS,
    input logic        NRST,
    input logic        PSEL,
    input logic        PENABLE,
    input logic [7:0]  PADDR,
    input logic [31:0] PRDATA,
    input logic        PREADY,
    input logic        PSLVERR,
    input logic        DDS_RESET_PIN,
    input logic        DAC_POWERDOWN_PIN,
    input logic [11:0] PHASE_OUT,
    input logic        DAC_POWERDOWN,
    input logic        LOGIC_OUTPUT_PIN,
    input logic        LOGIC_OUTPUT_OE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // bus answers: one wait, one-cycle pulse
    a_ready_one: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error flag without ready");
    a_err_map: assert property (PSEL && PENABLE && !PREADY
        |=> PSLVERR == ($past(PADDR) > 8'h18 ||
                        $past(PADDR[1:0]) != 2'b00))
        else $error("error flag wrong for address");
    a_reset_zero: assert property (
        DDS_RESET_PIN [*4] |-> PHASE_OUT == 12'h000)
        else $error("phase not cleared");
    a_pd_pin: assert property (
        DAC_POWERDOWN_PIN [*4] |-> DAC_POWERDOWN)
        else $error("dac not powered down");
    a_oe_gate: assert property (
        !LOGIC_OUTPUT_OE |-> !LOGIC_OUTPUT_PIN)
        else $error("logic pin driven while off");
    c_refused: cover property (PSLVERR);
    c_dds_reset: cover property (DDS_RESET_PIN [*4]);
    c_pd: cover property (DAC_POWERDOWN);
endmodule // dds_sel_checker

bind dds_tuning_select_control dds_sel_checker i_dds_sel_checker (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DDS_RESET_PIN(DDS_RESET_PIN), .DAC_POWERDOWN_PIN(DAC_POWERDOWN_PIN),
    .PHASE_OUT(PHASE_OUT), .DAC_POWERDOWN(DAC_POWERDOWN),
    .LOGIC_OUTPUT_PIN(LOGIC_OUTPUT_PIN), .LOGIC_OUTPUT_OE(LOGIC_OUTPUT_OE));

// File: testbench/dds_host_model.sv
`timescale 1ns/1ps
module dds_host_model (
    input  logic clk,
    output logic freq_sel,
    output logic phase_sel,
    output logic dds_rst,
    output logic pd,
    output logic comp
);
    // pins start low so nothing is requested
    initial {freq_sel, phase_sel, dds_rst, pd, comp} = 5'h00;
    task automatic set_pins(input logic [3:0] v);
        {freq_sel, phase_sel, dds_rst, pd} <= v;
    endtask
    // comparator result held as a level, changed on an edge
    task automatic set_comp(input logic v);
        @(posedge clk);
        comp <= v;
    endtask
endmodule // dds_host_model

// File: testbench/dds_tuning_select_control_tb_top.sv
`timescale 1ns/1ps
module dds_tuning_select_control_tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd, a0;
    logic        rdy, slv, fp, pp, rp, dp, cr, dpd, cis, lop, loe, err;
    logic [11:0] ph;
    logic [31:0] mdl [0:4] = '{default: 32'h0};
    logic [5:0]  ctl [0:4] = '{6'h09, 6'h31, 6'h11, 6'h21, 6'h01};
    logic [3:0]  outs [0:4] = '{4'h8, 4'h7, 4'h2, 4'h0, 4'h8};
    int          errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          tc, c0;

    dds_tuning_select_control i_dds_tuning_select_control (
        .CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(rdy), .PSLVERR(slv), .FREQ_SELECT_PIN(fp),
        .PHASE_SELECT_PIN(pp), .DDS_RESET_PIN(rp),
        .DAC_POWERDOWN_PIN(dp), .COMPARATOR_RESULT(cr), .PHASE_OUT(ph),
        .DAC_POWERDOWN(dpd), .COMPARATOR_INPUT_SEL(cis),
        .LOGIC_OUTPUT_PIN(lop), .LOGIC_OUTPUT_OE(loe));
    dds_host_model i_dds_host_model (.clk(clk), .freq_sel(fp),
        .phase_sel(pp), .dds_rst(rp), .pd(dp), .comp(cr));

    always #10 clk = ~clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer, then an idle edge so psel is never set twice at once
    task automatic apb(input logic w, input int i, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= 8'(i * 4);
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        err = slv;
        tc = cyc;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // model write: each field masked to its width
    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, i, d);
        mdl[i] = d & (i == 0 ? 32'h3F : i < 3 ? 32'h0FFFFFFF : 32'hFFF);
    endtask
    task automatic rdall();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, i, 32'h0);
            chk(rd, mdl[i]);
        end
    endtask
    // accumulator gain between two reads is cycles times the word
    task automatic step(input int i);
        apb(1'b0, 6, 32'h0);
        a0 = rd;
        c0 = tc;
        apb(1'b0, 6, 32'h0);
        chk((rd - a0) & 32'h0FFFFFFF, ((tc - c0) * mdl[i]) & 32'h0FFFFFFF);
    endtask

    initial begin
        void'($urandom(32'hB2F7CD99));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdall();
        apb(1'b0, 7, 32'h0);
        chk(err, 32'h1);
        for (int i = 0; i < 5; i++)
            wr(i, $urandom());
        rdall();
        $display("done registers");
        // pins stand opposite to the bits while the bits govern
        for (int m = 0; m < 4; m++) begin
            wr(0, m[1] ? 32'h4 : 32'(m[0]));
            i_dds_host_model.set_pins({m[0] ^ !m[1], 3'h0});
            repeat (5) @(posedge clk);
            step(1 + m[0]);
        end
        $display("done frequency");
        i_dds_host_model.set_pins(4'h2);
        repeat (5) @(posedge clk);
        apb(1'b0, 6, 32'h0);
        chk(rd, 32'h0);
        chk(32'(ph), 32'h0);
        apb(1'b0, 5, 32'h0);
        chk(rd, 32'h8);
        rdall();
        $display("done reset");
        // zero step keeps the accumulator at 0, offsets show bare
        wr(2, 32'h0);
        wr(0, 32'h1);
        i_dds_host_model.set_pins(4'hA);
        repeat (5) @(posedge clk);
        for (int m = 0; m < 4; m++) begin
            wr(0, m[1] ? 32'h4 : (m[0] ? 32'h3 : 32'h1));
            i_dds_host_model.set_pins({1'b1, m[0] ^ !m[1], 2'h0});
            repeat (5) @(posedge clk);
            chk(32'(ph), mdl[3 + m[0]]);
        end
        $display("done phase");
        // word b is zero, so the msb stays low; comparator held high
        i_dds_host_model.set_comp(1'b1);
        for (int m = 0; m < 5; m++) begin
            wr(0, {26'h0, ctl[m]});
            i_dds_host_model.set_pins({3'h0, m == 4});
            repeat (5) @(posedge clk);
            chk({28'h0, dpd, cis, loe, lop}, 32'(outs[m]));
        end
        $display("done outputs");
        end_sim();
    end
endmodule // dds_tuning_select_control_tb_top
